// *** dv/mri_host.sv ***
// host model: bus controller, bus listener and serial terminal
module mri_host (
	input wire logic clk,
	input wire logic [7:0] d,
	input wire logic dav,
	input wire logic nrfd,
	input wire logic ndac,
	input wire logic txd,
	output logic [7:0] d_h,
	output logic dav_h,
	output logic nrfd_h,
	output logic ndac_h,
	output logic atn_h,
	output logic rxd
);
	timeunit 1ns;
	timeprecision 1ns;
	// all lines released and serial line idle
	initial
	begin
		d_h = 8'hff;
		{dav_h, nrfd_h, ndac_h, atn_h, rxd} = 5'h1f;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	// bounded wait on a line: 0 dav, 1 nrfd, 2 ndac, 3 txd
	task automatic wl(input int s, input logic v);
		for (int k = 0; k < 9000; k++)
		begin
			if ((s == 0 ? dav : s == 1 ? nrfd : s == 2 ? ndac : txd) === v)
				return;
			tick(1);
		end
		testbench.hang();
	endtask
	// source one byte, under attention when atn is set
	task automatic bsend(input logic [7:0] b, input logic atn);
		nrfd_h = 1;
		ndac_h = 1;
		atn_h = !atn;
		tick(3);
		wl(1, 1);
		d_h = ~b;
		tick(2);
		dav_h = 0;
		wl(2, 1);
		dav_h = 1;
		d_h = 8'hff;
		tick(4);
	endtask
	// become listener and drop attention so the device talks
	task automatic lstart();
		nrfd_h = 0;
		ndac_h = 0;
		tick(1);
		atn_h = 1;
	endtask
	// accept one byte from the talking device
	task automatic brecv(output logic [7:0] b);
		nrfd_h = 1;
		wl(0, 0);
		b = ~d;
		nrfd_h = 0;
		ndac_h = 1;
		wl(0, 1);
		ndac_h = 0;
	endtask
	// serial frame out at the device's own bit period, no flow control
	task automatic ssend(input logic [7:0] b, input int dv);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			rxd = f[i];
			tick(dv);
		end
	endtask
	// serial frame in, sampled mid bit
	task automatic srecv(output logic [7:0] b, input int dv);
		wl(3, 0);
		tick(dv / 2);
		for (int i = 0; i < 8; i++)
		begin
			tick(dv);
			b[i] = txd;
		end
	endtask
endmodule

// *** dv/testbench.sv ***
// self-checking bench for the meter remote interface
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic SYS_CLK = 0, RST = 1, CFG_EDIT = 0, CFG_LINK_IN = 0, CFG_CONFIRM = 0, CFG_CANCEL = 0;
	logic [4:0] CFG_ADDR_IN = 5'h00, ACT_ADDR;
	logic [1:0] CFG_BAUD_IN = 2'h0, ACT_BAUD;
	logic IN_RD = 0, OUT_WR = 0, SVC_REQ = 0, IFC_N_IN = 1, REN_N_IN = 0, LOCAL_KEY = 0;
	logic eoi_h = 1, last_eoi, MSG_END, DEV_CLEAR, OUT_FULL, EOI_OE;
	logic [7:0] OUT_DATA = 8'h00, STB_IN = 8'h81, b, d_h, DIO_N_OUT, IN_DATA;
	logic dav_h, nrfd_h, ndac_h, atn_h, RXD, TXD, ACT_LINK, DIO_OE, DAV_OE, NRFD_OE, NDAC_OE;
	logic SRQ_OE, IN_VALID, REMOTE, LOCKOUT, LISTEN, TALK;
	logic [7:0] qry [6] = '{8'h2a, 8'h69, 8'h64, 8'h6e, 8'h3f, 8'h0a};
	int mismatches = 0, num_checks = 0, ends = 0, clrs = 0;
	// wired lines: any party pulling low wins
	wire logic [7:0] DIO_N_IN = d_h & (DIO_OE ? DIO_N_OUT : 8'hff);
	wire logic DAV_N_IN = dav_h & !DAV_OE;
	wire logic NRFD_N_IN = nrfd_h & !NRFD_OE;
	wire logic NDAC_N_IN = ndac_h & !NDAC_OE;
	wire logic EOI_N_IN = eoi_h & !EOI_OE;
	always #10 SYS_CLK = ~SYS_CLK;
	// one-cycle pulses counted; END level kept while the device drives DAV
	always @(negedge SYS_CLK)
	begin
		ends += MSG_END;
		clrs += DEV_CLEAR;
		if (DAV_OE)
			last_eoi = EOI_OE;
	end
	mri_top #(.DIV_1200(128), .DIV_2400(64), .DIV_4800(32), .DIV_9600(16)) dut_u (
		.SYS_CLK, .RST, .CFG_EDIT, .CFG_LINK_IN, .CFG_ADDR_IN, .CFG_BAUD_IN, .CFG_CONFIRM,
		.CFG_CANCEL, .ACT_LINK, .ACT_ADDR, .ACT_BAUD, .DIO_N_IN, .DIO_N_OUT, .DIO_OE, .DAV_N_IN,
		.DAV_N_OUT(), .DAV_OE, .NRFD_N_IN, .NRFD_N_OUT(), .NRFD_OE, .NDAC_N_IN, .NDAC_N_OUT(),
		.NDAC_OE, .EOI_N_IN, .EOI_N_OUT(), .EOI_OE, .SRQ_N_OUT(), .SRQ_OE,
		.ATN_N_IN(atn_h), .IFC_N_IN, .REN_N_IN, .RXD, .TXD, .IN_RD, .IN_DATA,
		.IN_VALID, .MSG_END, .OUT_WR, .OUT_DATA, .OUT_FULL, .SVC_REQ, .STB_IN,
		.LOCAL_KEY, .REMOTE, .LOCKOUT, .LISTEN, .TALK, .DEV_CLEAR
	);
	mri_host host_u (.clk(SYS_CLK), .d(DIO_N_IN), .dav(DAV_N_IN), .nrfd(NRFD_N_IN),
		.ndac(NDAC_N_IN), .txd(TXD), .d_h, .dav_h, .nrfd_h, .ndac_h, .atn_h, .rxd(RXD));
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic hang();
		mismatches++;
		report_and_stop();
	endtask
	// edit then confirm or cancel the stored setup
	task automatic cfg(input logic lk, input logic [1:0] bd, input logic ok);
		CFG_EDIT = 1;
		CFG_LINK_IN = lk;
		CFG_ADDR_IN = 5'h03;
		CFG_BAUD_IN = bd;
		@(negedge SYS_CLK);
		CFG_EDIT = 0;
		CFG_CONFIRM = ok;
		CFG_CANCEL = !ok;
		@(negedge SYS_CLK);
		CFG_CONFIRM = 0;
		CFG_CANCEL = 0;
		repeat (2) @(negedge SYS_CLK);
	endtask
	// setup, addressing, identity reply, poll, clear, then serial at each rate
	initial
	begin
		repeat (2) @(negedge SYS_CLK);
		RST = 0;
		check({ACT_LINK, ACT_ADDR, ACT_BAUD, DIO_OE, SRQ_OE, TXD, LISTEN, TALK}, 13'h464);
		cfg(0, 2'h3, 0);
		check(ACT_ADDR, 8);
		cfg(0, 2'h3, 1);
		check(ACT_ADDR, 3);
		host_u.bsend(8'h24, 1);
		check(LISTEN, 0);
		host_u.bsend(8'h23, 1);
		check({LISTEN, REMOTE}, 3);
		host_u.bsend(8'h08, 1);
		host_u.bsend(8'h11, 1);
		check({LISTEN, LOCKOUT}, 3);
		LOCAL_KEY = 1;
		@(negedge SYS_CLK);
		LOCAL_KEY = 0;
		check(REMOTE, 1);
		host_u.bsend(8'h01, 1);
		check(REMOTE, 0);
		REN_N_IN = 1;
		@(negedge SYS_CLK);
		REN_N_IN = 0;
		check(LOCKOUT, 0);
		foreach (qry[i])
			host_u.bsend(qry[i], 0);
		check({IN_VALID, IN_DATA}, 9'h12a);
		check(ends, 1);
		eoi_h = 0;
		host_u.bsend(8'h41, 0);
		eoi_h = 1;
		check(ends, 2);
		host_u.bsend(8'h43, 1);
		check(TALK, 1);
		host_u.lstart();
		for (int i = 0; i < 16; i++)
		begin
			host_u.brecv(b);
			check(b, i < 15 ? mri_pkg::ID_STR[8*(14-i) +: 8] : 8'h0a);
		end
		check(last_eoi, 1);
		host_u.bsend(8'h23, 1);
		check({TALK, LISTEN}, 1);
		host_u.bsend(8'h3f, 1);
		check(LISTEN, 0);
		SVC_REQ = 1;
		host_u.bsend(8'h18, 1);
		check(SRQ_OE, 1);
		host_u.bsend(8'h43, 1);
		host_u.lstart();
		host_u.brecv(b);
		check(b, 8'hc1);
		check(last_eoi, 0);
		host_u.tick(3);
		check(SRQ_OE, 0);
		SVC_REQ = 0;
		repeat (128)
		begin
			OUT_WR = 1;
			@(negedge SYS_CLK);
		end
		OUT_WR = 0;
		check(OUT_FULL, 1);
		host_u.bsend(8'h19, 1);
		host_u.bsend(8'h14, 1);
		check({IN_VALID, OUT_FULL}, 0);
		check(clrs, 1);
		IFC_N_IN = 0;
		@(negedge SYS_CLK);
		IFC_N_IN = 1;
		check({TALK, LISTEN}, 0);
		for (int r = 0; r < 4; r++)
		begin
			cfg(1, r[1:0], 1);
			check({ACT_LINK, ACT_BAUD}, {1'b1, r[1:0]});
			host_u.ssend(8'h5a + r[7:0], 128 >> r);
			host_u.tick(3);
			check({IN_VALID, IN_DATA}, {1'b1, 8'h5a + r[7:0]});
			IN_RD = 1;
			OUT_WR = 1;
			OUT_DATA = 8'ha5 ^ r[7:0];
			@(negedge SYS_CLK);
			IN_RD = 0;
			OUT_WR = 0;
			host_u.srecv(b, 128 >> r);
			check(b, 8'ha5 ^ r[7:0]);
		end
		report_and_stop();
	end
endmodule

// *** include/mri_pkg.sv ***
// constants, state types and helper functions for the meter remote interface
// Behaviour
// - source handshake sends multi-byte messages to bus listeners
// - acceptor handshake receives multi-byte messages from the bus
// - talker with serial poll, unaddressed by own listen address, no talk-only
// - listener entered only on own listen address under ATN
// - no listen-only mode; never listens unless addressed
// - SRQ asserted while service is needed until polled; controller finds requester by poll
// - remote/local control obeying go-to-local and local lockout
// - no parallel poll response on the data lines
// - device clear empties both queues and the id reply; addressing and remote state are kept
// - group execute trigger is ignored
// - never a controller: no ATN, IFC or REN drive, no addressing
// - listen and talk addressing needs the configured address; unlisten and other talk addresses unaddress
// - serial bit rate selectable as 1200, 2400, 4800 or 9600 baud
// - serial frame is start, eight data bits, no parity, one stop
// - serial link has no flow control; transmitter never waits
// - serial port uses only receive and transmit data, no modem lines
// - stored link, address and rate; pending edit committed or cancelled
// - identification query answered with maker, model and firmware fields
// - serial link is point to point with no station addressing
// - input and output queues hold 128 bytes; serial input and user writes beyond that are lost
// - bus message ends on line feed, END, or both
// - serial messages end with a line feed
package mri_pkg;
	localparam int CLK_HZ = 50_000_000;
	localparam int CLK_NS = 20;
	localparam int DIV_1200 = CLK_HZ / 1200;
	localparam int DIV_2400 = CLK_HZ / 2400;
	localparam int DIV_4800 = CLK_HZ / 4800;
	localparam int DIV_9600 = CLK_HZ / 9600;
	localparam int SETTLE_NS = 2000;
	localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int QDEPTH = 128;
	localparam logic [1:0] BAUD_1200 = 2'h0;
	localparam logic [1:0] BAUD_2400 = 2'h1;
	localparam logic [1:0] BAUD_4800 = 2'h2;
	localparam logic [1:0] BAUD_9600 = 2'h3;
	localparam logic LINK_BUS = 1'h0;
	localparam logic LINK_SER = 1'h1;
	localparam logic RST_LINK = 1'h0;
	localparam logic [4:0] RST_ADDR = 5'h08;
	localparam logic [1:0] RST_BAUD = 2'h3;
	localparam logic [7:0] CMD_GTL = 8'h01;
	localparam logic [7:0] CMD_SDC = 8'h04;
	localparam logic [7:0] CMD_GET = 8'h08;
	localparam logic [7:0] CMD_LLO = 8'h11;
	localparam logic [7:0] CMD_DCL = 8'h14;
	localparam logic [7:0] CMD_SPE = 8'h18;
	localparam logic [7:0] CMD_SPD = 8'h19;
	localparam logic [7:0] CMD_UNL = 8'h3f;
	localparam logic [7:0] CMD_UNT = 8'h5f;
	localparam logic [1:0] GRP_LISTEN = 2'h1;
	localparam logic [1:0] GRP_TALK = 2'h2;
	localparam logic [7:0] CH_LF = 8'h0a;
	// identification reply; text is arbitrary
	localparam int ID_LEN = 15;
	localparam logic [8*ID_LEN-1:0] ID_STR = "ACME,MTR-1,V0.0";
	localparam int QRY_LEN = 5;
	localparam logic [8*QRY_LEN-1:0] QRY_STR = "*IDN?";
	typedef enum logic [2:0] {
		AH_IDLE = 3'h0, AH_NRDY = 3'h1, AH_RDY = 3'h2, AH_ACPT = 3'h3, AH_WAIT = 3'h4
	} mri_ah_type;
	typedef enum logic [1:0] {
		SH_IDLE = 2'h0, SH_SETL = 2'h1, SH_XFER = 2'h2, SH_WAIT = 2'h3
	} mri_sh_type;
	// fold lower-case letters to upper case
	function automatic logic [7:0] upcase(input logic [7:0] b);
		return (b >= 8'h61 && b <= 8'h7a) ? b - 8'h20 : b;
	endfunction
	function automatic logic [7:0] id_char(input logic [3:0] i);
		return ID_STR[8*(ID_LEN-1-int'(i)) +: 8];
	endfunction
	function automatic logic [7:0] qry_char(input logic [2:0] i);
		return QRY_STR[8*(QRY_LEN-1-int'(i)) +: 8];
	endfunction
endpackage

// *** rtl/mri_top.sv ***
// remote interface of the meter: instrument bus port, serial port and queues
module mri_top #(
	parameter int unsigned DIV_1200 = mri_pkg::DIV_1200,
	parameter int unsigned DIV_2400 = mri_pkg::DIV_2400,
	parameter int unsigned DIV_4800 = mri_pkg::DIV_4800,
	parameter int unsigned DIV_9600 = mri_pkg::DIV_9600
) (
	input wire logic SYS_CLK,
	input wire logic RST,
	input wire logic CFG_EDIT,
	input wire logic CFG_LINK_IN,
	input wire logic [4:0] CFG_ADDR_IN,
	input wire logic [1:0] CFG_BAUD_IN,
	input wire logic CFG_CONFIRM,
	input wire logic CFG_CANCEL,
	output logic ACT_LINK,
	output logic [4:0] ACT_ADDR,
	output logic [1:0] ACT_BAUD,
	input wire logic [7:0] DIO_N_IN,
	output logic [7:0] DIO_N_OUT,
	output logic DIO_OE,
	input wire logic DAV_N_IN,
	output logic DAV_N_OUT,
	output logic DAV_OE,
	input wire logic NRFD_N_IN,
	output logic NRFD_N_OUT,
	output logic NRFD_OE,
	input wire logic NDAC_N_IN,
	output logic NDAC_N_OUT,
	output logic NDAC_OE,
	input wire logic EOI_N_IN,
	output logic EOI_N_OUT,
	output logic EOI_OE,
	output logic SRQ_N_OUT,
	output logic SRQ_OE,
	input wire logic ATN_N_IN,
	input wire logic IFC_N_IN,
	input wire logic REN_N_IN,
	input wire logic RXD,
	output logic TXD,
	input wire logic IN_RD,
	output logic [7:0] IN_DATA,
	output logic IN_VALID,
	output logic MSG_END,
	input wire logic OUT_WR,
	input wire logic [7:0] OUT_DATA,
	output logic OUT_FULL,
	input wire logic SVC_REQ,
	input wire logic [7:0] STB_IN,
	input wire logic LOCAL_KEY,
	output logic REMOTE,
	output logic LOCKOUT,
	output logic LISTEN,
	output logic TALK,
	output logic DEV_CLEAR
);
	mri_pkg::mri_ah_type ah_r, ah_nxt;
	mri_pkg::mri_sh_type sh_r, sh_nxt;
	logic pend_link_r, act_link_r;
	logic [4:0] pend_addr_r, act_addr_r;
	logic [1:0] pend_baud_r, act_baud_r;
	logic [7:0] rx_byte_r, dio_r, cmd, in_byte, oq_in, oq_head, idg_byte, iq_fwd, oq_byte;
	logic rx_atn_r, rx_eoi_r, eoi_r, sp_byte_r, sp_sent_r, rqs_r, polled_r, polled_nxt;
	logic listen_r, talk_r, spoll_r, remote_r, lockout_r, low_r;
	logic [6:0] settle_r;
	logic bus_on, atn, dav, nrfd_in, ndac_in, acc_act, sh_ok, sh_done, own;
	logic cmd_v, is_mla, is_unl, is_tag, is_mta, is_ota, is_get;
	logic dc_acc, gtl_acc, bus_data, in_stb, term, id_go;
	logic [2:0] idm_r, idm_adv;
	logic [3:0] idg_r;
	logic idg_busy_r, idg_wr;
	logic [7:0] iq_mem [mri_pkg::QDEPTH];
	logic [7:0] oq_mem [mri_pkg::QDEPTH];
	logic [6:0] iq_wr_r, iq_rd_r, iq_rd_nxt, oq_wr_r, oq_rd_r;
	logic [7:0] iq_cnt_r, iq_cnt_nxt, oq_cnt_r, oq_cnt_nxt;
	logic iq_wen, iq_pop, oq_wen, oq_pop, utx_go, utx_busy, urx_stb;
	logic [7:0] urx_byte;
	logic [15:0] baud_div;

	// bus lines are active low; the serial link selection turns the bus off
	assign bus_on = act_link_r == mri_pkg::LINK_BUS;
	assign atn = !ATN_N_IN;
	assign dav = !DAV_N_IN;
	assign nrfd_in = !NRFD_N_IN;
	assign ndac_in = !NDAC_N_IN;

	// stored setup: edits go to the pending copy until confirmed or cancelled
	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
		begin
			pend_link_r <= mri_pkg::RST_LINK;
			pend_addr_r <= mri_pkg::RST_ADDR;
			pend_baud_r <= mri_pkg::RST_BAUD;
			act_link_r <= mri_pkg::RST_LINK;
			act_addr_r <= mri_pkg::RST_ADDR;
			act_baud_r <= mri_pkg::RST_BAUD;
		end
		else if (CFG_CONFIRM)
		begin
			act_link_r <= pend_link_r;
			act_addr_r <= pend_addr_r;
			act_baud_r <= pend_baud_r;
		end
		else if (CFG_CANCEL)
		begin
			pend_link_r <= act_link_r;
			pend_addr_r <= act_addr_r;
			pend_baud_r <= act_baud_r;
		end
		else if (CFG_EDIT)
		begin
			pend_link_r <= CFG_LINK_IN;
			pend_addr_r <= CFG_ADDR_IN;
			pend_baud_r <= CFG_BAUD_IN;
		end
	end
	assign ACT_LINK = act_link_r;
	assign ACT_ADDR = act_addr_r;
	assign ACT_BAUD = act_baud_r;

	// acceptor handshake: accept under ATN always, data only while addressed
	assign acc_act = bus_on && (atn || listen_r);
	always_comb
	begin
		ah_nxt = ah_r;
		case (ah_r)
			mri_pkg::AH_IDLE: ah_nxt = mri_pkg::AH_NRDY;
			mri_pkg::AH_NRDY: if (atn || iq_cnt_r != 8'(mri_pkg::QDEPTH)) ah_nxt = mri_pkg::AH_RDY;
			mri_pkg::AH_RDY: if (dav) ah_nxt = mri_pkg::AH_ACPT;
			mri_pkg::AH_ACPT: ah_nxt = mri_pkg::AH_WAIT;
			mri_pkg::AH_WAIT: if (!dav) ah_nxt = mri_pkg::AH_NRDY;
			default: ah_nxt = mri_pkg::AH_IDLE;
		endcase
		if (!acc_act)
			ah_nxt = mri_pkg::AH_IDLE;
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
		begin
			ah_r <= mri_pkg::AH_IDLE;
			NRFD_OE <= 1'b0;
			NDAC_OE <= 1'b0;
			rx_byte_r <= 8'h0;
			rx_atn_r <= 1'b0;
			rx_eoi_r <= 1'b0;
		end
		else
		begin
			ah_r <= ah_nxt;
			NRFD_OE <= ah_nxt inside {mri_pkg::AH_NRDY, mri_pkg::AH_ACPT, mri_pkg::AH_WAIT};
			NDAC_OE <= ah_nxt inside {mri_pkg::AH_NRDY, mri_pkg::AH_RDY, mri_pkg::AH_ACPT};
			if (ah_r == mri_pkg::AH_RDY && dav)
			begin
				rx_byte_r <= ~DIO_N_IN;
				rx_atn_r <= atn;
				rx_eoi_r <= !EOI_N_IN;
			end
		end
	end

	// interface command decode for a byte accepted under ATN; trigger falls through
	assign cmd_v = ah_r == mri_pkg::AH_ACPT && rx_atn_r;
	assign cmd = {1'b0, rx_byte_r[6:0]};
	assign own = cmd[4:0] == act_addr_r;
	assign is_unl = cmd_v && cmd == mri_pkg::CMD_UNL;
	assign is_mla = cmd_v && cmd[6:5] == mri_pkg::GRP_LISTEN && own && !is_unl;
	assign is_tag = cmd_v && cmd[6:5] == mri_pkg::GRP_TALK;
	assign is_mta = is_tag && own && cmd != mri_pkg::CMD_UNT;
	assign is_ota = is_tag && !is_mta;
	assign is_get = cmd_v && cmd == mri_pkg::CMD_GET;
	assign gtl_acc = cmd_v && cmd == mri_pkg::CMD_GTL && listen_r;
	assign dc_acc = cmd_v && (cmd == mri_pkg::CMD_DCL || (cmd == mri_pkg::CMD_SDC && listen_r));

	// addressing state; IFC or leaving the bus unaddresses everything
	always_ff @(posedge SYS_CLK)
	begin
		if (RST || !IFC_N_IN || !bus_on)
		begin
			listen_r <= 1'b0;
			talk_r <= 1'b0;
			spoll_r <= 1'b0;
		end
		else
		begin
			if (is_mla)
				listen_r <= 1'b1;
			else if (is_unl)
				listen_r <= 1'b0;
			if (is_mta)
				talk_r <= 1'b1;
			else if (is_ota || is_mla)
				talk_r <= 1'b0;
			if (cmd_v && cmd == mri_pkg::CMD_SPE)
				spoll_r <= 1'b1;
			else if (cmd_v && cmd == mri_pkg::CMD_SPD)
				spoll_r <= 1'b0;
		end
	end

	// remote/local: REN false drops both; front-panel local blocked by lockout
	always_ff @(posedge SYS_CLK)
	begin
		if (RST || REN_N_IN || !bus_on)
		begin
			remote_r <= 1'b0;
			lockout_r <= 1'b0;
		end
		else
		begin
			if (cmd_v && cmd == mri_pkg::CMD_LLO)
				lockout_r <= 1'b1;
			if (is_mla)
				remote_r <= 1'b1;
			else if (gtl_acc || (LOCAL_KEY && !lockout_r))
				remote_r <= 1'b0;
		end
	end

	// source handshake: serial poll byte or queued data; ATN aborts at once
	assign sh_ok = talk_r && !atn && bus_on;
	assign sh_done = sh_r == mri_pkg::SH_XFER && !ndac_in;
	always_comb
	begin
		sh_nxt = sh_r;
		case (sh_r)
			mri_pkg::SH_IDLE: if (spoll_r ? !sp_sent_r : oq_cnt_r != 8'h0) sh_nxt = mri_pkg::SH_SETL;
			mri_pkg::SH_SETL: if (settle_r == 7'h0 && !nrfd_in) sh_nxt = mri_pkg::SH_XFER;
			mri_pkg::SH_XFER: if (!ndac_in) sh_nxt = mri_pkg::SH_WAIT;
			default: sh_nxt = mri_pkg::SH_IDLE;
		endcase
		if (!sh_ok)
			sh_nxt = mri_pkg::SH_IDLE;
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
		begin
			sh_r <= mri_pkg::SH_IDLE;
			settle_r <= 7'h0;
			dio_r <= 8'h0;
			eoi_r <= 1'b0;
			sp_byte_r <= 1'b0;
		end
		else
		begin
			sh_r <= sh_nxt;
			if (sh_r == mri_pkg::SH_IDLE)
			begin
				settle_r <= 7'(mri_pkg::SETTLE_CYC - 1);
				sp_byte_r <= spoll_r;
				dio_r <= spoll_r ? {STB_IN[7], rqs_r, STB_IN[5:0]} : oq_head;
				eoi_r <= !spoll_r && oq_head == mri_pkg::CH_LF;
			end
			else if (settle_r != 7'h0)
				settle_r <= settle_r - 7'h1;
		end
	end

	// bus drive flops; EOI only with data, never under ATN, so no poll reply
	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
		begin
			DIO_N_OUT <= 8'hff;
			DIO_OE <= 1'b0;
			DAV_OE <= 1'b0;
			EOI_OE <= 1'b0;
			low_r <= 1'b0;
		end
		else
		begin
			DIO_N_OUT <= ~dio_r;
			DIO_OE <= sh_nxt != mri_pkg::SH_IDLE && sh_r != mri_pkg::SH_IDLE;
			DAV_OE <= sh_nxt == mri_pkg::SH_XFER;
			EOI_OE <= eoi_r && sh_nxt inside {mri_pkg::SH_SETL, mri_pkg::SH_XFER};
			low_r <= 1'b0;
		end
	end
	assign DAV_N_OUT = low_r;
	assign NRFD_N_OUT = low_r;
	assign NDAC_N_OUT = low_r;
	assign EOI_N_OUT = low_r;
	assign SRQ_N_OUT = low_r;

	// service request held off after a poll until the request drops
	assign polled_nxt = SVC_REQ && (polled_r || (sh_done && sp_byte_r && rqs_r));
	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
		begin
			polled_r <= 1'b0;
			rqs_r <= 1'b0;
			SRQ_OE <= 1'b0;
			sp_sent_r <= 1'b0;
		end
		else
		begin
			polled_r <= polled_nxt;
			rqs_r <= SVC_REQ && !polled_nxt && bus_on;
			SRQ_OE <= SVC_REQ && !polled_nxt && bus_on;
			if (dc_acc || (cmd_v && (cmd == mri_pkg::CMD_SPE || cmd == mri_pkg::CMD_SPD)))
				sp_sent_r <= 1'b0;
			else if (sh_done && sp_byte_r)
				sp_sent_r <= 1'b1;
		end
	end

	// incoming byte stream from whichever link is active
	assign bus_data = ah_r == mri_pkg::AH_ACPT && !rx_atn_r && listen_r;
	assign in_stb = bus_data || (!bus_on && urx_stb);
	assign in_byte = bus_on ? rx_byte_r : urx_byte;
	assign term = in_stb && (in_byte == mri_pkg::CH_LF || (bus_on && rx_eoi_r));

	// identification query match; reply queued when its terminator arrives
	assign idm_adv = (idm_r < 3'(mri_pkg::QRY_LEN)
		&& mri_pkg::upcase(in_byte) == mri_pkg::qry_char(idm_r)) ? idm_r + 3'h1 : 3'h0;
	assign id_go = term && ((in_byte == mri_pkg::CH_LF && idm_r == 3'(mri_pkg::QRY_LEN))
		|| idm_adv == 3'(mri_pkg::QRY_LEN));
	assign idg_byte = idg_r == 4'(mri_pkg::ID_LEN) ? mri_pkg::CH_LF : mri_pkg::id_char(idg_r);
	assign idg_wr = idg_busy_r && !OUT_WR && oq_cnt_r != 8'(mri_pkg::QDEPTH);
	always_ff @(posedge SYS_CLK)
	begin
		if (RST || dc_acc)
		begin
			idm_r <= 3'h0;
			idg_r <= 4'h0;
			idg_busy_r <= 1'b0;
		end
		else
		begin
			if (in_stb)
				idm_r <= term ? 3'h0 : idm_adv;
			if (id_go && !idg_busy_r)
				idg_busy_r <= 1'b1;
			else if (idg_wr)
			begin
				idg_busy_r <= idg_r != 4'(mri_pkg::ID_LEN);
				idg_r <= idg_r == 4'(mri_pkg::ID_LEN) ? 4'h0 : idg_r + 4'h1;
			end
		end
	end

	// input queue: a byte arriving while full is dropped
	assign iq_wen = in_stb && iq_cnt_r != 8'(mri_pkg::QDEPTH);
	assign iq_pop = IN_RD && iq_cnt_r != 8'h0;
	assign iq_rd_nxt = iq_rd_r + {6'h0, iq_pop};
	assign iq_cnt_nxt = dc_acc ? 8'h0 : iq_cnt_r + {7'h0, iq_wen} - {7'h0, iq_pop};
	assign iq_fwd = (iq_wen && iq_wr_r == iq_rd_nxt) ? in_byte : iq_mem[iq_rd_nxt];
	always_ff @(posedge SYS_CLK)
	begin
		if (iq_wen)
			iq_mem[iq_wr_r] <= in_byte;
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (RST || dc_acc)
		begin
			iq_wr_r <= 7'h0;
			iq_rd_r <= 7'h0;
			iq_cnt_r <= 8'h0;
			IN_DATA <= 8'h0;
			IN_VALID <= 1'b0;
		end
		else
		begin
			iq_wr_r <= iq_wr_r + {6'h0, iq_wen};
			iq_rd_r <= iq_rd_nxt;
			iq_cnt_r <= iq_cnt_nxt;
			IN_DATA <= iq_fwd;
			IN_VALID <= iq_cnt_nxt != 8'h0;
		end
	end

	// output queue: user writes win over the id reply; user excess is dropped
	assign oq_wen = (OUT_WR || idg_wr) && oq_cnt_r != 8'(mri_pkg::QDEPTH);
	assign oq_in = OUT_WR ? OUT_DATA : idg_byte;
	assign oq_head = oq_mem[oq_rd_r];
	assign utx_go = !bus_on && !utx_busy && oq_cnt_r != 8'h0;
	assign oq_byte = oq_head;
	assign oq_pop = (sh_done && !sp_byte_r) || utx_go;
	assign oq_cnt_nxt = dc_acc ? 8'h0 : oq_cnt_r + {7'h0, oq_wen} - {7'h0, oq_pop};
	always_ff @(posedge SYS_CLK)
	begin
		if (oq_wen)
			oq_mem[oq_wr_r] <= oq_in;
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (RST || dc_acc)
		begin
			oq_wr_r <= 7'h0;
			oq_rd_r <= 7'h0;
			oq_cnt_r <= 8'h0;
			OUT_FULL <= 1'b0;
		end
		else
		begin
			oq_wr_r <= oq_wr_r + {6'h0, oq_wen};
			oq_rd_r <= oq_rd_r + {6'h0, oq_pop};
			oq_cnt_r <= oq_cnt_nxt;
			OUT_FULL <= oq_cnt_nxt == 8'(mri_pkg::QDEPTH);
		end
	end

	// status pulses toward the rest of the meter
	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
		begin
			MSG_END <= 1'b0;
			DEV_CLEAR <= 1'b0;
		end
		else
		begin
			MSG_END <= term;
			DEV_CLEAR <= dc_acc;
		end
	end
	assign REMOTE = remote_r;
	assign LOCKOUT = lockout_r;
	assign LISTEN = listen_r;
	assign TALK = talk_r;

	// serial port: only data in and data out, rate from the stored setting
	assign baud_div = act_baud_r == mri_pkg::BAUD_1200 ? 16'(DIV_1200)
		: act_baud_r == mri_pkg::BAUD_2400 ? 16'(DIV_2400)
		: act_baud_r == mri_pkg::BAUD_4800 ? 16'(DIV_4800) : 16'(DIV_9600);
	mri_uart u_uart (
		.clk(SYS_CLK),
		.rst(RST || bus_on),
		.div(baud_div),
		.rxd(RXD),
		.tx_go(utx_go),
		.tx_byte(oq_byte),
		.txd(TXD),
		.tx_busy(utx_busy),
		.rx_stb(urx_stb),
		.rx_byte(urx_byte)
	);

	// checks
	property p_listen;
		@(posedge SYS_CLK) disable iff (RST) $rose(LISTEN) |-> $past(is_mla);
	endproperty
	a_listen: assert property (p_listen) else $error("listener without own address");
	property p_noser;
		@(posedge SYS_CLK) disable iff (RST) !bus_on |=> !LISTEN && !NRFD_OE && !NDAC_OE;
	endproperty
	a_noser: assert property (p_noser) else $error("bus acceptor active on serial link");
	property p_unt;
		@(posedge SYS_CLK) disable iff (RST) is_mla |=> !TALK;
	endproperty
	a_unt: assert property (p_unt) else $error("talker kept after own listen address");
	property p_other;
		@(posedge SYS_CLK) disable iff (RST)
			cmd_v && cmd[6:5] == mri_pkg::GRP_LISTEN && !own && !LISTEN |=> !LISTEN;
	endproperty
	a_other: assert property (p_other) else $error("listened to a foreign address");
	property p_gtl;
		@(posedge SYS_CLK) disable iff (RST) gtl_acc |=> !REMOTE;
	endproperty
	a_gtl: assert property (p_gtl) else $error("go to local ignored");
	property p_dcl;
		@(posedge SYS_CLK) disable iff (RST) dc_acc |=> DEV_CLEAR && !IN_VALID && !OUT_FULL;
	endproperty
	a_dcl: assert property (p_dcl) else $error("device clear left state");
	property p_get;
		@(posedge SYS_CLK) disable iff (RST)
			is_get && REN_N_IN == $past(REN_N_IN) && IFC_N_IN && !LOCAL_KEY
			|=> $stable(REMOTE) && $stable(LISTEN) && $stable(TALK) && !DEV_CLEAR;
	endproperty
	a_get: assert property (p_get) else $error("trigger changed state");
	property p_pp;
		@(posedge SYS_CLK) disable iff (RST) atn |=> !EOI_OE && !DIO_OE;
	endproperty
	a_pp: assert property (p_pp) else $error("data lines driven under ATN");
	property p_dav;
		@(posedge SYS_CLK) disable iff (RST) $rose(DAV_OE) |-> !$past(nrfd_in) && DIO_OE;
	endproperty
	a_dav: assert property (p_dav) else $error("DAV before ready or data");
	property p_srq;
		@(posedge SYS_CLK) disable iff (RST)
			SVC_REQ && bus_on && !polled_r && !sh_done |=> SRQ_OE;
	endproperty
	a_srq: assert property (p_srq) else $error("service request not signalled");
endmodule

// *** rtl/mri_uart.sv ***
// serial transmitter and receiver, 8 data bits, no parity, one stop bit
module mri_uart (
	input wire logic clk,
	input wire logic rst,
	input wire logic [15:0] div,
	input wire logic rxd,
	input wire logic tx_go,
	input wire logic [7:0] tx_byte,
	output logic txd,
	output logic tx_busy,
	output logic rx_stb,
	output logic [7:0] rx_byte
);
	logic [15:0] tx_cnt_r, rx_cnt_r;
	logic [3:0] tx_left_r, rx_left_r;
	logic [8:0] tx_sh_r;
	logic rx_busy_r;

	// transmitter: start bit, data lsb first, stop bit; starts on request alone
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			txd <= 1'b1;
			tx_busy <= 1'b0;
			tx_cnt_r <= 16'h0;
			tx_left_r <= 4'h0;
			tx_sh_r <= 9'h1ff;
		end
		else if (!tx_busy && tx_go)
		begin
			txd <= 1'b0;
			tx_busy <= 1'b1;
			tx_sh_r <= {1'b1, tx_byte};
			tx_left_r <= 4'h9;
			tx_cnt_r <= div - 16'h1;
		end
		else if (tx_busy && tx_cnt_r != 16'h0)
			tx_cnt_r <= tx_cnt_r - 16'h1;
		else if (tx_busy && tx_left_r != 4'h0)
		begin
			txd <= tx_sh_r[0];
			tx_sh_r <= {1'b1, tx_sh_r[8:1]};
			tx_left_r <= tx_left_r - 4'h1;
			tx_cnt_r <= div - 16'h1;
		end
		else
			tx_busy <= 1'b0;
	end

	// receiver: checks start at mid bit, samples data, takes byte on valid stop
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rx_busy_r <= 1'b0;
			rx_cnt_r <= 16'h0;
			rx_left_r <= 4'h0;
			rx_stb <= 1'b0;
			rx_byte <= 8'h0;
		end
		else
		begin
			rx_stb <= 1'b0;
			if (!rx_busy_r)
			begin
				if (!rxd)
				begin
					rx_busy_r <= 1'b1;
					rx_cnt_r <= {1'b0, div[15:1]};
					rx_left_r <= 4'h9;
				end
			end
			else if (rx_cnt_r != 16'h0)
				rx_cnt_r <= rx_cnt_r - 16'h1;
			else if (rx_left_r == 4'h9 && rxd)
				rx_busy_r <= 1'b0; // glitch, not a start bit
			else if (rx_left_r != 4'h0)
			begin
				if (rx_left_r != 4'h9)
					rx_byte <= {rxd, rx_byte[7:1]};
				rx_left_r <= rx_left_r - 4'h1;
				rx_cnt_r <= div - 16'h1;
			end
			else
			begin
				rx_stb <= rxd;
				rx_busy_r <= 1'b0;
			end
		end
	end
endmodule
